/* File: uwcp_pkg.sv */
// uwcp_pkg: offsets, field positions and reset values of the write-only control plane
// assumes a byte-addressed word map: each printed offset is a register index, byte address = 4*index
package uwcp_pkg;
    // register indices as printed
    localparam logic [5:0] IDX_TIMER_RELOAD = 6'h01;
    localparam logic [5:0] IDX_TIMER_PRESCALE = 6'h02;
    localparam logic [5:0] IDX_POWER_DOWN = 6'h03;
    localparam logic [5:0] IDX_WATCHDOG_KICK = 6'h04;
    localparam logic [5:0] IDX_KEYSCAN_MASK = 6'h05;
    localparam logic [5:0] IDX_FACTORY_TEST = 6'h0f;
    localparam logic [5:0] IDX_USB_IRQ_EN = 6'h11;
    localparam logic [5:0] IDX_MISC_IRQ_EN = 6'h12;
    localparam logic [5:0] IDX_EP0_TX_BASE = 6'h18;
    localparam logic [5:0] IDX_EP1_TX_BASE = 6'h20;
    localparam logic [5:0] IDX_EP2_TX_BASE = 6'h28;
    // status word of our own: block state readable over the bus
    localparam logic [5:0] IDX_STATUS = 6'h30;
    // address width in bits
    localparam int ADDR_W = 8;
    localparam int ADDR_LSB = 2;
    // field positions
    localparam int PSC_W = 4;
    localparam int TEST_W = 4;
    localparam int USB_IE_LSB = 2;
    localparam int USB_IE_W = 6;
    localparam int KBD_MODE_BIT = 4;
    localparam int MISC_IE_W = 4;
    localparam int USB_SRC_N = 6;
    localparam int MISC_SRC_N = 4;
    // reset values
    localparam logic [7:0] RST_BYTE = 8'h00;
    // prescaler: one base tick every two instruction cycles
    localparam int BASE_DIV = 2;
    localparam logic [3:0] PSC_BYPASS = 4'h8;
    localparam int PSC_CNT_W = 8;
    localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;
endpackage

/* File: uwcp_top.sv */
// uwcp_top: write-only control register plane behind an avalon-mm slave
// assumes clk is the cpu instruction clock; event flags come from engines on the same clock
//
// How it works
// - 8-bit timer reload value, resets zero
// - prescale code picks timer division ratio
// - prescaler base tick every two cycles
// - any write at 0x03 with byte lane 0 enabled enters power-down
// - write at 0x04 clears, enables watchdog
// - mask bit one blocks keyscan line interrupt
// - three 8-byte endpoint transmit buffers
// - six usb interrupt enables at 0x11
// - bit 4 of 0x12 selects keyboard mode
// - bits 3..0 enable resume/kbd/pb0/timer interrupts
//
// Implementation choice: the Avalon-MM register port.
`timescale 1ns/1ps
module uwcp_top (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // avalon-mm slave
    input wire logic [uwcp_pkg::ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // timer control
    output logic [7:0] timer_reload_value,
    output logic [3:0] timer_prescale_select,
    output logic timer_tick,
    // power and watchdog
    output logic power_down_req,
    output logic watchdog_clear,
    output logic watchdog_enable,
    // keyboard scan
    output logic [7:0] keyscan_interrupt_mask,
    output logic keyboard_port_mode_select,
    output logic [3:0] factory_test_control,
    // endpoint transmit buffers, 8 bytes each flattened
    output logic [63:0] ep0_transmit_buffer,
    output logic [63:0] ep1_transmit_buffer,
    output logic [63:0] ep2_transmit_buffer,
    // interrupt sources: usb {rc0,tx0,tx1,tx2,reset,suspend}, misc {resume,kbd,pb0,timer}
    input wire logic [uwcp_pkg::USB_SRC_N-1:0] usb_event_pending,
    input wire logic [uwcp_pkg::MISC_SRC_N-1:0] misc_event_pending,
    output logic cpu_irq
);

    logic [5:0] idx;
    logic wr_stb;
    logic rd_stb;
    logic rd_done_r;
    logic [7:0] wbyte;
    logic [5:0] usb_ie_r;
    logic [3:0] misc_ie_r;
    logic wr_reload;
    logic wr_prescale;
    logic wr_power_down;
    logic wr_kick;
    logic wr_keyscan;
    logic wr_test;
    logic wr_usb_ie;
    logic wr_misc_ie;
    logic ep_hit;
    logic [4:0] ep_off;
    logic ep0_wr;
    logic ep1_wr;
    logic ep2_wr;
    logic usb_irq_hit;
    logic misc_irq_hit;
    logic [2:0] div_cnt_r;
    logic base_tick_r;
    logic [uwcp_pkg::PSC_CNT_W-1:0] psc_cnt_r;
    logic [uwcp_pkg::PSC_CNT_W-1:0] psc_limit;

    assign idx = avs_address[uwcp_pkg::ADDR_W-1:uwcp_pkg::ADDR_LSB];
    // byte 0 lane carries the register; other lanes are ignored
    assign wbyte = avs_writedata[7:0];
    assign wr_stb = avs_write & avs_byteenable[0];
    assign rd_stb = avs_read & ~rd_done_r;

    // one strobe per register; writes to undefined offsets match none
    assign wr_reload = wr_stb && idx == uwcp_pkg::IDX_TIMER_RELOAD;
    assign wr_prescale = wr_stb && idx == uwcp_pkg::IDX_TIMER_PRESCALE;
    assign wr_power_down = wr_stb && idx == uwcp_pkg::IDX_POWER_DOWN;
    assign wr_kick = wr_stb && idx == uwcp_pkg::IDX_WATCHDOG_KICK;
    assign wr_keyscan = wr_stb && idx == uwcp_pkg::IDX_KEYSCAN_MASK;
    assign wr_test = wr_stb && idx == uwcp_pkg::IDX_FACTORY_TEST;
    assign wr_usb_ie = wr_stb && idx == uwcp_pkg::IDX_USB_IRQ_EN;
    assign wr_misc_ie = wr_stb && idx == uwcp_pkg::IDX_MISC_IRQ_EN;

    // the three buffers sit back to back, so the offset picks buffer and byte
    assign ep_hit = idx >= uwcp_pkg::IDX_EP0_TX_BASE && idx < uwcp_pkg::IDX_STATUS;
    assign ep_off = 5'(idx - uwcp_pkg::IDX_EP0_TX_BASE);
    assign ep0_wr = wr_stb && ep_hit && ep_off[4:3] == 2'h0;
    assign ep1_wr = wr_stb && ep_hit && ep_off[4:3] == 2'h1;
    assign ep2_wr = wr_stb && ep_hit && ep_off[4:3] == 2'h2;

    // a source interrupts only while its flag is pending and its enable is set
    assign usb_irq_hit = |(usb_event_pending & usb_ie_r);
    assign misc_irq_hit = |(misc_event_pending & misc_ie_r);

    // writes finish in the request cycle; reads take one wait cycle for a registered answer
    assign avs_waitrequest = avs_read & ~rd_done_r;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rd_done_r <= 1'b0;
        end else begin
            rd_done_r <= rd_stb;
        end
    end

    // reads return only status; control state is never touched by a read
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            avs_readdata <= 32'h0000_0000;
        end else if (rd_stb) begin
            if (idx == uwcp_pkg::IDX_STATUS) begin
                avs_readdata <= {16'h0000, 2'h0, usb_event_pending, misc_event_pending,
                                 2'h0, watchdog_enable, power_down_req};
            end else begin
                avs_readdata <= uwcp_pkg::UNMAPPED_READ;
            end
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            timer_reload_value <= uwcp_pkg::RST_BYTE;
        end else if (wr_reload) begin
            timer_reload_value <= wbyte;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            timer_prescale_select <= 4'h0;
        end else if (wr_prescale) begin
            timer_prescale_select <= wbyte[uwcp_pkg::PSC_W-1:0];
        end
    end

    // power-down holds until reset; the wake logic lives outside this block
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            power_down_req <= 1'b0;
        end else if (wr_power_down) begin
            power_down_req <= 1'b1;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            watchdog_clear <= 1'b0;
            watchdog_enable <= 1'b0;
        end else begin
            watchdog_clear <= wr_kick;
            if (wr_kick) begin
                watchdog_enable <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            keyscan_interrupt_mask <= uwcp_pkg::RST_BYTE;
        end else if (wr_keyscan) begin
            keyscan_interrupt_mask <= wbyte;
        end
    end

    // non-zero values are passed through untouched; keeping it zero is up to software
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            factory_test_control <= 4'h0;
        end else if (wr_test) begin
            factory_test_control <= wbyte[uwcp_pkg::TEST_W-1:0];
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            usb_ie_r <= 6'h00;
        end else if (wr_usb_ie) begin
            usb_ie_r <= wbyte[uwcp_pkg::USB_IE_LSB +: uwcp_pkg::USB_IE_W];
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            misc_ie_r <= 4'h0;
            keyboard_port_mode_select <= 1'b0;
        end else if (wr_misc_ie) begin
            misc_ie_r <= wbyte[uwcp_pkg::MISC_IE_W-1:0];
            keyboard_port_mode_select <= wbyte[uwcp_pkg::KBD_MODE_BIT];
        end
    end

    // each buffer takes its byte slot from the low offset bits
    uwcp_ep_buf #(
        .DEPTH(8)
    ) ep0_buf_i (
        .clk(clk),
        .nrst(nrst),
        .wr_en(ep0_wr),
        .wr_sel(ep_off[2:0]),
        .wr_byte(wbyte),
        .contents(ep0_transmit_buffer)
    );

    uwcp_ep_buf #(
        .DEPTH(8)
    ) ep1_buf_i (
        .clk(clk),
        .nrst(nrst),
        .wr_en(ep1_wr),
        .wr_sel(ep_off[2:0]),
        .wr_byte(wbyte),
        .contents(ep1_transmit_buffer)
    );

    uwcp_ep_buf #(
        .DEPTH(8)
    ) ep2_buf_i (
        .clk(clk),
        .nrst(nrst),
        .wr_en(ep2_wr),
        .wr_sel(ep_off[2:0]),
        .wr_byte(wbyte),
        .contents(ep2_transmit_buffer)
    );

    // base tick every two instruction cycles
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            div_cnt_r <= 3'h0;
            base_tick_r <= 1'b0;
        end else begin
            base_tick_r <= div_cnt_r == 3'(uwcp_pkg::BASE_DIV - 1);
            div_cnt_r <= (div_cnt_r == 3'(uwcp_pkg::BASE_DIV - 1)) ? 3'h0 : div_cnt_r + 3'h1;
        end
    end

    // code n<8 divides by 2^(n+1), code 8 bypasses; codes above 8 treated as bypass
    always_comb begin
        if (timer_prescale_select >= uwcp_pkg::PSC_BYPASS) begin
            psc_limit = 8'h00;
        end else begin
            psc_limit = 8'((9'h002 << timer_prescale_select[2:0]) - 9'h001);
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            psc_cnt_r <= 8'h00;
            timer_tick <= 1'b0;
        end else if (base_tick_r) begin
            timer_tick <= psc_cnt_r >= psc_limit;
            psc_cnt_r <= (psc_cnt_r >= psc_limit) ? 8'h00 : psc_cnt_r + 8'h01;
        end else begin
            timer_tick <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cpu_irq <= 1'b0;
        end else begin
            cpu_irq <= usb_irq_hit | misc_irq_hit;
        end
    end

endmodule

// one endpoint transmit buffer: a byte-wide write port, all bytes visible at once
module uwcp_ep_buf #(
    parameter int DEPTH = 8
) (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // byte write port
    input wire logic wr_en,
    input wire logic [$clog2(DEPTH)-1:0] wr_sel,
    input wire logic [7:0] wr_byte,
    // buffer contents, byte k at bits 8k+7:8k
    output logic [8*DEPTH-1:0] contents
);

    logic [7:0] mem_r [0:DEPTH-1];

    // buffer bytes carry no reset value; cleared anyway so outputs are never unknown
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_r[i] <= 8'h00;
            end
        end else if (wr_en) begin
            mem_r[wr_sel] <= wr_byte;
        end
    end

    always_comb begin
        for (int i = 0; i < DEPTH; i++) begin
            contents[8*i +: 8] = mem_r[i];
        end
    end

endmodule

/* File: uwcp_top_chk.sv */
// uwcp_top_chk: port-level checks of the write-only control plane
// assumes bound onto uwcp_top, single clock domain
`timescale 1ns/1ps
module uwcp_top_chk (
    // clock, reset and bus
    input wire logic clk,
    input wire logic nrst,
    input wire logic [uwcp_pkg::ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    input wire logic avs_waitrequest,
    // control outputs and irq
    input wire logic [7:0] timer_reload_value,
    input wire logic [3:0] timer_prescale_select,
    input wire logic power_down_req,
    input wire logic watchdog_clear,
    input wire logic watchdog_enable,
    input wire logic [7:0] keyscan_interrupt_mask,
    input wire logic keyboard_port_mode_select,
    input wire logic [uwcp_pkg::USB_SRC_N-1:0] usb_event_pending,
    input wire logic [uwcp_pkg::MISC_SRC_N-1:0] misc_event_pending,
    input wire logic cpu_irq
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    logic wr_ok;
    logic [5:0] idx;
    logic [7:0] wd8;
    logic [3:0] wd4;
    assign wr_ok = avs_write && avs_byteenable[0];
    assign idx = avs_address[7:2];
    assign wd8 = avs_writedata[7:0];
    assign wd4 = avs_writedata[3:0];
    sequence kick_seen; wr_ok && idx == uwcp_pkg::IDX_WATCHDOG_KICK; endsequence
    // a second kick right behind the first keeps the clear pulse up legally
    sequence kick_done;
        watchdog_clear && watchdog_enable ##1
            (!watchdog_clear || $past(wr_ok && idx == uwcp_pkg::IDX_WATCHDOG_KICK));
    endsequence
    reload_write_a: assert property (wr_ok && idx == uwcp_pkg::IDX_TIMER_RELOAD |=>
        timer_reload_value == $past(wd8)) else $error("reload value not taken");
    prescale_write_a: assert property (wr_ok && idx == uwcp_pkg::IDX_TIMER_PRESCALE |=>
        timer_prescale_select == $past(wd4)) else $error("prescale code not taken");
    power_down_a: assert property (wr_ok && idx == uwcp_pkg::IDX_POWER_DOWN |=> power_down_req)
        else $error("power down not entered");
    watchdog_kick_a: assert property (kick_seen |=> kick_done) else $error("watchdog kick wrong");
    keyscan_mask_a: assert property (wr_ok && idx == uwcp_pkg::IDX_KEYSCAN_MASK |=>
        keyscan_interrupt_mask == $past(wd8)) else $error("keyscan mask not taken");
    kbd_mode_a: assert property (wr_ok && idx == uwcp_pkg::IDX_MISC_IRQ_EN && wd8[4] |=>
        keyboard_port_mode_select) else $error("keyboard mode not set");
    irq_quiet_a: assert property (usb_event_pending == 0 && misc_event_pending == 0 |=> !cpu_irq)
        else $error("irq without pending event");
    read_harmless_a: assert property (avs_read |=> $stable(timer_reload_value) &&
        $stable(keyscan_interrupt_mask) && $stable(watchdog_enable)) else $error("read changed state");
    read_answer_a: assert property ($rose(avs_read) |-> avs_waitrequest ##1 !avs_waitrequest)
        else $error("read answer late");
endmodule
bind uwcp_top uwcp_top_chk uwcp_top_chk_i (.clk(clk), .nrst(nrst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_waitrequest(avs_waitrequest),
    .timer_reload_value(timer_reload_value), .timer_prescale_select(timer_prescale_select),
    .power_down_req(power_down_req), .watchdog_clear(watchdog_clear), .watchdog_enable(watchdog_enable),
    .keyscan_interrupt_mask(keyscan_interrupt_mask), .keyboard_port_mode_select(keyboard_port_mode_select),
    .usb_event_pending(usb_event_pending), .misc_event_pending(misc_event_pending), .cpu_irq(cpu_irq));

/* File: uwcp_top_bench.sv */
// uwcp_top_bench: directed scenarios for the write-only control plane
// assumes the checker binds itself in; outputs judged at the falling edge
`timescale 1ns/1ps
module uwcp_top_bench;
    logic clk = 1'b0, nrst = 1'b0, rd = 1'b0, wr = 1'b0;
    logic [7:0] adr = 8'h00, rl, msk;
    logic [31:0] wd = 32'h0, rdat, q;
    logic [3:0] be = 4'h1, misc = 4'h0, ps, ft;
    logic [5:0] usb = 6'h00;
    logic [63:0] b0, b1, b2;
    logic tk, pd, wc, we, km, irq, wq;
    int error_cnt = 0, compares = 0, cyc = 0;
    always #20 clk = ~clk;
    uwcp_top uwcp_top_i (.clk(clk), .nrst(nrst), .avs_address(adr), .avs_read(rd), .avs_write(wr),
        .avs_writedata(wd), .avs_byteenable(be), .avs_readdata(rdat), .avs_waitrequest(wq),
        .timer_reload_value(rl), .timer_prescale_select(ps), .timer_tick(tk), .power_down_req(pd),
        .watchdog_clear(wc), .watchdog_enable(we), .keyscan_interrupt_mask(msk),
        .keyboard_port_mode_select(km), .factory_test_control(ft), .ep0_transmit_buffer(b0),
        .ep1_transmit_buffer(b1), .ep2_transmit_buffer(b2), .usb_event_pending(usb),
        .misc_event_pending(misc), .cpu_irq(irq));
    task automatic final_report();
        if (error_cnt == 0 && compares > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(string n, logic [191:0] e, logic [191:0] g);
        compares++;
        if (g !== e) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc > 4000) begin
            error_cnt++;
            final_report();
        end
    end
    // one transfer; held until waitrequest is seen low at a rising edge, only the timeout ends a hang
    task automatic bus(logic w, logic [5:0] i, logic [7:0] d, logic [3:0] e);
        @(posedge clk);
        adr <= {i, 2'b00};
        wd <= {24'h0, d};
        be <= e;
        if (w) wr <= 1'b1;
        else rd <= 1'b1;
        do begin
            @(posedge clk);
        end while (wq !== 1'b0);
        q = rdat;
        wr <= 1'b0;
        rd <= 1'b0;
        @(negedge clk);
    endtask
    // a second reset in mid-run must clear the sticky power-down and watchdog state too
    task automatic t_reset();
        @(posedge clk);
        nrst <= 1'b0;
        @(posedge clk);
        nrst <= 1'b1;
        @(negedge clk);
        chk("reset again", 192'h0, {b0 | b1 | b2, rl, ps, pd, wc, we, msk, km, ft, irq, tk});
    endtask
    task automatic t_regs();
        bus(1, uwcp_pkg::IDX_TIMER_RELOAD, 8'ha5, 4'h1);
        chk("reload", 8'ha5, rl);
        bus(1, uwcp_pkg::IDX_TIMER_RELOAD, 8'h3c, 4'h0);
        bus(1, uwcp_pkg::IDX_KEYSCAN_MASK, 8'h81, 4'h1);
        bus(1, uwcp_pkg::IDX_FACTORY_TEST, 8'hf0, 4'h1);
        bus(1, 6'h3f, 8'hff, 4'h1);
        bus(0, 6'h3f, 8'h00, 4'h1);
        chk("unmapped read", 32'h0, q);
        chk("reload mask test", {8'ha5, 8'h81, 4'h0}, {rl, msk, ft});
    endtask
    task automatic t_power();
        bus(0, uwcp_pkg::IDX_STATUS, 8'h00, 4'h1);
        chk("status idle", 32'h0, q);
        bus(1, uwcp_pkg::IDX_WATCHDOG_KICK, 8'h00, 4'h1);
        chk("kick", 2'b11, {wc, we});
        @(negedge clk);
        chk("kick end", 2'b01, {wc, we});
        bus(1, uwcp_pkg::IDX_POWER_DOWN, 8'h5a, 4'h1);
        chk("power down", 1'b1, pd);
    endtask
    task automatic t_bufs();
        logic [191:0] e;
        for (int k = 0; k < 24; k++) begin
            e[8*k +: 8] = 8'(k + 8'h40);
            bus(1, uwcp_pkg::IDX_EP0_TX_BASE + 6'(k), 8'(k + 8'h40), 4'h1);
        end
        chk("ep buffers", e, {b2, b1, b0});
    endtask
    task automatic t_irq();
        @(posedge clk);
        usb <= 6'h3e;
        misc <= 4'he;
        bus(1, uwcp_pkg::IDX_USB_IRQ_EN, 8'h04, 4'h1);
        @(negedge clk);
        chk("usb irq masked", 1'b0, irq);
        @(posedge clk);
        usb <= 6'h01;
        repeat (2) @(negedge clk);
        chk("suspend irq", 1'b1, irq);
        @(posedge clk);
        usb <= 6'h00;
        bus(1, uwcp_pkg::IDX_MISC_IRQ_EN, 8'h11, 4'h1);
        chk("mode no irq", 2'b10, {km, irq});
        @(posedge clk);
        misc <= 4'h1;
        repeat (2) @(negedge clk);
        chk("timer irq", 1'b1, irq);
        bus(0, uwcp_pkg::IDX_STATUS, 8'h00, 4'h1);
        chk("status set", 32'h13, q);
    endtask
    // tick spacing is base tick of two cycles times the division ratio
    task automatic tick_period(logic [3:0] c, int e);
        int n;
        bus(1, uwcp_pkg::IDX_TIMER_PRESCALE, {4'ha, c}, 4'h1);
        chk("prescale", c, ps);
        for (int k = 0; k < 3; k++) begin
            n = 0;
            do begin
                @(negedge clk);
                n++;
            end while (tk !== 1'b1 && n < 600);
        end
        chk("tick period", e, n);
    endtask
    initial begin
        repeat (8) @(posedge clk);
        nrst <= 1'b1;
        @(negedge clk);
        chk("reset outputs", 192'h0, {b0 | b1 | b2, rl, ps, pd, wc, we, msk, km, ft, irq, tk});
        t_regs();
        t_power();
        t_bufs();
        t_irq();
        t_reset();
        tick_period(4'h0, 4);
        tick_period(4'h1, 8);
        tick_period(4'h7, 512);
        tick_period(4'h8, 2);
        final_report();
    end
endmodule
